// file: core/pcs_regs.svh
// Address, width and depth constants of the program sequencer
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH
`define PCS_PC_W        11
`define PCS_WORD_W      14
`define PCS_SHORT_W     8
`define PCS_STACK_DEPTH 8
`define PCS_PC_ONE      11'h001
`define PCS_PC_TWO      11'h002
`define PCS_RESET_VEC   11'h000
`define PCS_SWI_VEC     11'h001
`define PCS_HWI_VEC     11'h008
`define PCS_PRESET_LO   11'h00E
`define PCS_PRESET_HI   11'h00F
`define PCS_RSVD_LO     11'h7FE
`define PCS_WORD_ZERO   14'h0000
`endif

// file: core/pcs_pkg.sv
// Types shared by the program sequencer modules
`default_nettype none
`include "pcs_regs.svh"
package pcs_pkg;
  typedef logic [`PCS_PC_W-1:0]   pcs_addr_t;
  typedef logic [`PCS_WORD_W-1:0] pcs_word_t;

  // Flow control operations issued by instruction decode
  typedef enum logic [3:0] {
    PCS_OP_SEQ,
    PCS_OP_SKIP,
    PCS_OP_SHORT_JUMP,
    PCS_OP_SHORT_CALL,
    PCS_OP_LONG_JUMP,
    PCS_OP_LONG_CALL,
    PCS_OP_PLAIN_RETURN,
    PCS_OP_RETURN_WITH_LITERAL,
    PCS_OP_RETURN_FROM_INTERRUPT,
    PCS_OP_SOFT_INT,
    PCS_OP_HW_INT
  } pcs_op_t;

  // One command of one instruction cycle
  typedef struct packed {
    pcs_op_t   op;
    pcs_addr_t target;
  } pcs_cmd_t;

  // Sequencer state
  typedef struct packed {
    pcs_addr_t program_counter;
    logic      bubble;
    logic      released;
    pcs_word_t word;
  } pcs_core_t;
endpackage : pcs_pkg
`default_nettype wire

// file: core/pcs_stack.sv
// Circular hardware return stack
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"
module pcs_stack #(
  parameter int unsigned DEPTH = `PCS_STACK_DEPTH
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  // Stack operations
  input  wire logic              push_i,
  input  wire logic              pop_i,
  input  wire pcs_pkg::pcs_addr_t push_addr_i,
  output pcs_pkg::pcs_addr_t     top_o
);
  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0]                  ptr;
    logic [DEPTH-1:0][`PCS_PC_W-1:0] entry;
  } pcs_stk_t;

  pcs_stk_t stk_ff;
  pcs_stk_t nxt_stk;

  // Top entry seen by the sequencer
  assign top_o = stk_ff.entry[stk_ff.ptr];

  // Pointer wraps, so a push onto a full stack overwrites the oldest entry
  always_comb begin
    nxt_stk = stk_ff;
    if (push_i) begin
      nxt_stk.ptr                = stk_ff.ptr + PW'(1); // RQ12
      nxt_stk.entry[nxt_stk.ptr] = push_addr_i;          // RQ7
    end else if (pop_i) begin
      nxt_stk.ptr = stk_ff.ptr - PW'(1);                 // RQ8
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      stk_ff <= '0;
    end else begin
      stk_ff <= nxt_stk;
    end
  end

  a_push_top : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ7
    push_i |=> top_o == $past(push_addr_i))
    else $error("pushed address not on top");
  a_wrap_oldest : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ12
    push_i |=> stk_ff.ptr == $past(stk_ff.ptr) + PW'(1))
    else $error("stack pointer did not advance on push");
endmodule : pcs_stack
`default_nettype wire

// file: core/pcs_top.sv
// Program counter and return stack sequencer
//
// Contract
// RQ1 - Program counter is 11 bits wide, covering all 2K program words.
// RQ2 - Power-on reset loads program counter with 0x000; fetching starts there.
// RQ3 - A software interrupt redirects execution to address 0x001.
// RQ4 - Every hardware interrupt redirects execution to the shared vector 0x008.
// RQ5 - Short jump and short call reach only 256 program locations.
// RQ6 - Long call and long jump reach any program location.
// RQ7 - Calls and interrupts push the next program word address onto the stack.
// RQ8 - Plain return, literal return and interrupt return pop the top into counter.
// RQ9 - Loader keeps code out of reserved words 0x7FE to 0x7FF.
// RQ10 - Words 0x00E to 0x00F hold a preset code until released for use.
// RQ11 - Instructions take one cycle; branches and skips take two cycles.
// RQ12 - Stack is eight deep; a full push overwrites the oldest, no flag.
// RQ13 - Short forms place the 8-bit target low and clear the upper bits.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"
module pcs_top #(
  parameter int unsigned       DEPTH       = `PCS_STACK_DEPTH,
  parameter pcs_pkg::pcs_word_t PRESET_LO  = 14'h2A5, // Arbitrary preset code value
  parameter pcs_pkg::pcs_word_t PRESET_HI  = 14'h15A  // Arbitrary preset code value
) (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               reset_i,
  // Instruction decode command
  input  wire logic               cmd_valid_i,
  input  wire pcs_pkg::pcs_cmd_t  cmd_i,
  // Preset code release
  input  wire logic               release_i,
  // Program memory
  input  wire pcs_pkg::pcs_word_t mem_word_i,
  output pcs_pkg::pcs_addr_t      fetch_addr_o,
  output pcs_pkg::pcs_word_t      word_o,
  // Status
  output logic                    bubble_o,
  output logic                    released_o
);
  // ****************************************************************
  // Decoding helpers
  // ****************************************************************

  // Operations that take a second instruction cycle
  function automatic logic pcs_two_cycle(input pcs_pkg::pcs_op_t op);
    pcs_two_cycle = (op != pcs_pkg::PCS_OP_SEQ);
  endfunction : pcs_two_cycle

  // Operations that pop the return stack
  function automatic logic pcs_is_return(input pcs_pkg::pcs_op_t op);
    pcs_is_return = (op == pcs_pkg::PCS_OP_PLAIN_RETURN) ||
                    (op == pcs_pkg::PCS_OP_RETURN_WITH_LITERAL) ||
                    (op == pcs_pkg::PCS_OP_RETURN_FROM_INTERRUPT);
  endfunction : pcs_is_return

  // Operations that push the return stack
  function automatic logic pcs_is_push(input pcs_pkg::pcs_op_t op);
    pcs_is_push = (op == pcs_pkg::PCS_OP_SHORT_CALL) ||
                  (op == pcs_pkg::PCS_OP_LONG_CALL) ||
                  (op == pcs_pkg::PCS_OP_SOFT_INT) ||
                  (op == pcs_pkg::PCS_OP_HW_INT);
  endfunction : pcs_is_push

  // Short target: low bits from the command, upper bits cleared
  function automatic pcs_pkg::pcs_addr_t pcs_short(input pcs_pkg::pcs_addr_t t);
    pcs_short = {{(`PCS_PC_W - `PCS_SHORT_W){1'b0}}, t[`PCS_SHORT_W-1:0]};
  endfunction : pcs_short

  // ****************************************************************
  // State
  // ****************************************************************

  pcs_pkg::pcs_core_t core_ff;
  pcs_pkg::pcs_core_t nxt_core;
  pcs_pkg::pcs_addr_t stack_top;
  pcs_pkg::pcs_addr_t ret_addr;
  logic               push;
  logic               pop;
  logic               take;

  // Return address is the word after the current one
  assign ret_addr = core_ff.program_counter + `PCS_PC_ONE;
  assign take     = cmd_valid_i && !core_ff.bubble;

  // Next state of counter, bubble, release flag and fetched word
  always_comb begin
    nxt_core = core_ff;
    push     = 1'b0;
    pop      = 1'b0;
    if (release_i) begin
      nxt_core.released = 1'b1;
    end
    // Preset words overlay memory until released
    if (!core_ff.released && (core_ff.program_counter == `PCS_PRESET_LO)) begin
      nxt_core.word = PRESET_LO; // RQ10
    end else if (!core_ff.released && (core_ff.program_counter == `PCS_PRESET_HI)) begin
      nxt_core.word = PRESET_HI; // RQ10
    end else begin
      nxt_core.word = mem_word_i;
    end
    if (cmd_valid_i && core_ff.bubble) begin
      nxt_core.bubble = 1'b0; // RQ11
    end else if (take) begin
      nxt_core.bubble = pcs_two_cycle(cmd_i.op); // RQ11
      push            = pcs_is_push(cmd_i.op);  // RQ7
      pop             = pcs_is_return(cmd_i.op); // RQ8
      case (cmd_i.op)
        pcs_pkg::PCS_OP_SEQ: begin
          nxt_core.program_counter = ret_addr; // RQ11
        end
        pcs_pkg::PCS_OP_SKIP: begin
          nxt_core.program_counter = core_ff.program_counter + `PCS_PC_TWO;
        end
        pcs_pkg::PCS_OP_SHORT_JUMP, pcs_pkg::PCS_OP_SHORT_CALL: begin
          nxt_core.program_counter = pcs_short(cmd_i.target); // RQ5 RQ13
        end
        pcs_pkg::PCS_OP_LONG_JUMP, pcs_pkg::PCS_OP_LONG_CALL: begin
          nxt_core.program_counter = cmd_i.target; // RQ6
        end
        pcs_pkg::PCS_OP_PLAIN_RETURN, pcs_pkg::PCS_OP_RETURN_WITH_LITERAL,
        pcs_pkg::PCS_OP_RETURN_FROM_INTERRUPT: begin
          nxt_core.program_counter = stack_top; // RQ8
        end
        pcs_pkg::PCS_OP_SOFT_INT: begin
          nxt_core.program_counter = `PCS_SWI_VEC; // RQ3
        end
        pcs_pkg::PCS_OP_HW_INT: begin
          nxt_core.program_counter = `PCS_HWI_VEC; // RQ4
        end
        default: begin
          nxt_core.program_counter = ret_addr;
        end
      endcase
    end
  end

  // State register; reset vector and preset code held
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      core_ff.program_counter <= `PCS_RESET_VEC; // RQ1 RQ2
      core_ff.bubble          <= 1'b0;
      core_ff.released        <= 1'b0;
      core_ff.word            <= `PCS_WORD_ZERO;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // ****************************************************************
  // Return stack
  // ****************************************************************

  pcs_stack #(
    .DEPTH       (DEPTH)
  ) u_stack (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_addr_i (ret_addr),
    .top_o       (stack_top)
  );

  // Outputs straight from state
  assign fetch_addr_o = core_ff.program_counter;
  assign word_o       = core_ff.word;
  assign bubble_o     = core_ff.bubble;
  assign released_o   = core_ff.released;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  a_reset_vector : assert property (@(posedge sys_clk_i) // RQ2
    reset_i |=> fetch_addr_o == `PCS_RESET_VEC && !bubble_o)
    else $error("reset did not load address zero");
  a_soft_vector : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ3
    take && cmd_i.op == pcs_pkg::PCS_OP_SOFT_INT |=> fetch_addr_o == `PCS_SWI_VEC)
    else $error("software interrupt vector wrong");
  a_hw_vector : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ4
    take && cmd_i.op == pcs_pkg::PCS_OP_HW_INT |=> fetch_addr_o == `PCS_HWI_VEC)
    else $error("hardware interrupt vector wrong");
  a_short_reach : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ5
    take && (cmd_i.op == pcs_pkg::PCS_OP_SHORT_JUMP || cmd_i.op == pcs_pkg::PCS_OP_SHORT_CALL)
    |=> fetch_addr_o == pcs_short($past(cmd_i.target)))
    else $error("short branch target wrong");
  a_long_reach : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ6
    take && (cmd_i.op == pcs_pkg::PCS_OP_LONG_JUMP || cmd_i.op == pcs_pkg::PCS_OP_LONG_CALL)
    |=> fetch_addr_o == $past(cmd_i.target))
    else $error("long branch target wrong");
  a_call_return : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ7
    take && cmd_i.op == pcs_pkg::PCS_OP_LONG_CALL
    ##1 cmd_valid_i ##1 take && cmd_i.op == pcs_pkg::PCS_OP_PLAIN_RETURN
    |=> fetch_addr_o == $past(fetch_addr_o, 3) + `PCS_PC_ONE)
    else $error("return did not come back after call");
  a_pop_load : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ8
    take && pcs_is_return(cmd_i.op) |=> fetch_addr_o == $past(stack_top))
    else $error("return did not load stack top");
  a_preset_word : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ10
    !released_o && fetch_addr_o == `PCS_PRESET_LO && !release_i |=> word_o == PRESET_LO)
    else $error("preset code not presented");
  a_one_cycle : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ11
    take && cmd_i.op == pcs_pkg::PCS_OP_SEQ |=> !bubble_o && fetch_addr_o == $past(fetch_addr_o) + `PCS_PC_ONE)
    else $error("sequential step wrong");
  a_two_cycle : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ11
    take && pcs_two_cycle(cmd_i.op) |=> bubble_o)
    else $error("branch bubble not raised");
  a_bubble_clear : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ11
    bubble_o && cmd_valid_i |=> !bubble_o && $stable(fetch_addr_o))
    else $error("second branch cycle did not clear the bubble");
  a_bubble_hold : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ11
    bubble_o && !cmd_valid_i |=> bubble_o && $stable(fetch_addr_o))
    else $error("bubble or counter moved without a strobe");
  a_skip_two : assert property (@(posedge sys_clk_i) disable iff (reset_i) // RQ11
    take && cmd_i.op == pcs_pkg::PCS_OP_SKIP |=> fetch_addr_o == $past(fetch_addr_o) + `PCS_PC_TWO)
    else $error("skip did not pass one word");

  c_call : cover property (@(posedge sys_clk_i) disable iff (reset_i)
    take && cmd_i.op == pcs_pkg::PCS_OP_SHORT_CALL);
  c_hw_int : cover property (@(posedge sys_clk_i) disable iff (reset_i)
    take && cmd_i.op == pcs_pkg::PCS_OP_HW_INT);
  c_return : cover property (@(posedge sys_clk_i) disable iff (reset_i)
    take && cmd_i.op == pcs_pkg::PCS_OP_RETURN_FROM_INTERRUPT);
  c_release : cover property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(released_o));
endmodule : pcs_top
`default_nettype wire

// file: verification/pcs_mem_model.sv
// Program memory model that answers the sequencer fetch port
`timescale 1ns/1ps
`default_nettype none
module pcs_mem_model (
  // Fetch port
  input  wire pcs_pkg::pcs_addr_t addr_i,
  output var  pcs_pkg::pcs_word_t word_o
);
  // Each code word carries its own address; the reserved top words hold no code
  always_comb begin
    if (addr_i >= 11'h7FE) begin
      word_o = 14'h3FFF;
    end else begin
      word_o = {3'h0, addr_i};
    end
  end
endmodule : pcs_mem_model
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the program counter and return stack sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam pcs_pkg::pcs_word_t P_LO = 14'h0123;
  localparam pcs_pkg::pcs_word_t P_HI = 14'h0321;
  logic               sys_clk_i;
  logic               reset_i;
  logic               cmd_valid_i;
  pcs_pkg::pcs_cmd_t  cmd_i;
  logic               release_i;
  pcs_pkg::pcs_word_t mem_word;
  pcs_pkg::pcs_addr_t fetch_addr_o;
  pcs_pkg::pcs_word_t word_o;
  logic               bubble_o;
  logic               released_o;
  int                 num_errors;
  int                 total_checks;

  // Design and program memory
  pcs_top #(.PRESET_LO(P_LO), .PRESET_HI(P_HI)) DUT (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .release_i(release_i), .mem_word_i(mem_word), .fetch_addr_o(fetch_addr_o),
    .word_o(word_o), .bubble_o(bubble_o), .released_o(released_o));
  pcs_mem_model mem (.addr_i(fetch_addr_o), .word_o(mem_word));

  // ****************************************
  // Compare and drive tasks
  // ****************************************
  task automatic chk_a(input string n, input pcs_pkg::pcs_addr_t e, input pcs_pkg::pcs_addr_t g);
    total_checks++;
    if (g !== e) begin num_errors++; $display("[ERR] %s exp=%h got=%h", n, e, g); end
  endtask : chk_a
  task automatic chk_w(input string n, input pcs_pkg::pcs_word_t e, input pcs_pkg::pcs_word_t g);
    total_checks++;
    if (g !== e) begin num_errors++; $display("[ERR] %s exp=%h got=%h", n, e, g); end
  endtask : chk_w
  task automatic chk_f(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin num_errors++; $display("[ERR] %s exp=%b got=%b", n, e, g); end
  endtask : chk_f

  // One command, then the filler cycle that clears the bubble of a branch
  task automatic do_cmd(input pcs_pkg::pcs_op_t op, input pcs_pkg::pcs_addr_t t, input pcs_pkg::pcs_addr_t e);
    logic two;
    two = (op != pcs_pkg::PCS_OP_SEQ);
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i       <= {op, t};
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    #1;
    chk_a("fetch_addr", e, fetch_addr_o);
    chk_f("bubble", two, bubble_o);
    if (two) begin
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b1;
      cmd_i       <= {pcs_pkg::PCS_OP_SEQ, 11'h7FF};
      @(posedge sys_clk_i);
      cmd_valid_i <= 1'b0;
      #1;
      chk_f("bubble_clear", 1'b0, bubble_o);
      chk_a("held_addr", e, fetch_addr_o);
    end
  endtask : do_cmd

  // ****************************************
  // Scenarios
  // ****************************************
  // Sequential step, skip and both interrupt vectors with their returns
  task automatic t_flow;
    do_cmd(pcs_pkg::PCS_OP_SEQ, 11'h555, 11'h001);
    do_cmd(pcs_pkg::PCS_OP_SKIP, 11'h555, 11'h003);
    do_cmd(pcs_pkg::PCS_OP_HW_INT, 11'h000, 11'h008);
    do_cmd(pcs_pkg::PCS_OP_RETURN_FROM_INTERRUPT, 11'h000, 11'h004);
    do_cmd(pcs_pkg::PCS_OP_SOFT_INT, 11'h000, 11'h001);
    do_cmd(pcs_pkg::PCS_OP_PLAIN_RETURN, 11'h000, 11'h005);
  endtask : t_flow

  // Short forms drop the upper target bits; long forms reach the top
  task automatic t_reach;
    do_cmd(pcs_pkg::PCS_OP_SHORT_JUMP, 11'h7AB, 11'h0AB);
    do_cmd(pcs_pkg::PCS_OP_SHORT_CALL, 11'h7FF, 11'h0FF);
    do_cmd(pcs_pkg::PCS_OP_PLAIN_RETURN, 11'h000, 11'h0AC);
    do_cmd(pcs_pkg::PCS_OP_LONG_JUMP, 11'h7FC, 11'h7FC);
    do_cmd(pcs_pkg::PCS_OP_LONG_CALL, 11'h423, 11'h423);
    do_cmd(pcs_pkg::PCS_OP_RETURN_WITH_LITERAL, 11'h000, 11'h7FD);
  endtask : t_reach

  // Nine nested calls: the oldest return address is lost, the last eight come back
  task automatic t_stack;
    pcs_pkg::pcs_addr_t ret [9];
    pcs_pkg::pcs_op_t   rop [3];
    rop = '{pcs_pkg::PCS_OP_PLAIN_RETURN, pcs_pkg::PCS_OP_RETURN_WITH_LITERAL,
            pcs_pkg::PCS_OP_RETURN_FROM_INTERRUPT};
    do_cmd(pcs_pkg::PCS_OP_LONG_JUMP, 11'h050, 11'h050);
    for (int i = 0; i < 9; i++) begin
      ret[i] = (i == 0) ? 11'h051 : 11'(32'h101 + (i - 1) * 16);
      do_cmd(pcs_pkg::PCS_OP_LONG_CALL, 11'(32'h100 + i * 16), 11'(32'h100 + i * 16));
    end
    for (int i = 8; i > 0; i--) begin
      do_cmd(rop[i % 3], 11'h000, ret[i]);
    end
  endtask : t_stack

  // Call, ignored second cycle and return on consecutive edges, then back-to-back steps
  task automatic t_burst;
    do_cmd(pcs_pkg::PCS_OP_LONG_JUMP, 11'h230, 11'h230);
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i       <= {pcs_pkg::PCS_OP_LONG_CALL, 11'h345};
    @(posedge sys_clk_i);
    cmd_i       <= {pcs_pkg::PCS_OP_LONG_JUMP, 11'h111};
    #1;
    chk_a("burst_call", 11'h345, fetch_addr_o);
    @(posedge sys_clk_i);
    cmd_i       <= {pcs_pkg::PCS_OP_PLAIN_RETURN, 11'h000};
    #1;
    chk_a("burst_ignored", 11'h345, fetch_addr_o);
    @(posedge sys_clk_i);
    cmd_i       <= {pcs_pkg::PCS_OP_SEQ, 11'h000};
    #1;
    chk_a("burst_return", 11'h231, fetch_addr_o);
    @(posedge sys_clk_i);
    #1;
    chk_f("burst_bubble", 1'b0, bubble_o);
    @(posedge sys_clk_i);
    #1;
    chk_a("burst_seq1", 11'h232, fetch_addr_o);
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    #1;
    chk_a("burst_seq2", 11'h233, fetch_addr_o);
  endtask : t_burst

  // Reset in mid-run returns to the reset vector and drops the release flag
  task automatic t_rerun;
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    #1;
    chk_a("rerun_addr", 11'h000, fetch_addr_o);
    chk_w("rerun_word", 14'h0000, word_o);
    chk_f("rerun_released", 1'b0, released_o);
    do_cmd(pcs_pkg::PCS_OP_SEQ, 11'h000, 11'h001);
  endtask : t_rerun

  // Preset words overlay the memory until released
  task automatic t_preset;
    do_cmd(pcs_pkg::PCS_OP_LONG_JUMP, 11'h00E, 11'h00E);
    chk_w("preset_lo", P_LO, word_o);
    do_cmd(pcs_pkg::PCS_OP_SEQ, 11'h000, 11'h00F);
    @(posedge sys_clk_i);
    #1;
    chk_w("preset_hi", P_HI, word_o);
    @(posedge sys_clk_i);
    release_i <= 1'b1;
    @(posedge sys_clk_i);
    release_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    chk_f("released", 1'b1, released_o);
    chk_w("released_word", 14'h000F, word_o);
  endtask : t_preset

  // Verdict and end of run
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // Clock of 4 ns period
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // Run limit
  initial begin
    #400000;
    num_errors++;
    $display("[ERR] run_limit exp=done got=hang");
    wrap_up();
  end

  // Main sequence
  initial begin
    num_errors   = 0;
    total_checks = 0;
    reset_i      = 1'b1;
    cmd_valid_i  = 1'b0;
    cmd_i        = '0;
    release_i    = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    #1;
    chk_a("reset_addr", 11'h000, fetch_addr_o);
    chk_f("reset_bubble", 1'b0, bubble_o);
    chk_f("reset_released", 1'b0, released_o);
    t_flow();
    t_reach();
    t_stack();
    t_burst();
    t_preset();
    t_rerun();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
